//--- logic/ftes_core.sv
// Frame-transfer exposure sequencer with APB register slave.
// Assumes one 200 MHz clock; the sync pin is asynchronous; the sensor
// driver shifts rows on o_row_shift and o_xfer timing set here.
`default_nettype none
// How it works
// - Software mode captures the requested frame count back to back, ignoring sync.
// - Sensing half and storage half are shifted by separate strobes.
// - Free-run: after exposure, transfer to storage, then expose again at once.
// - Storage half is read out while the next exposure runs.
// - External sync mode reads one frame per accepted sync; source limits rate.
// - First frame after first sync is discarded; later frames are stored.
// - In sync mode exposure lasts from one sync to the next.
// - No exposure ends before the storage-half readout has finished.
// - Actual exposure is time between transfers; may exceed programmed value.
// - Sync during readout is held; sync after readout acts at once.
// - Sync accepted on falling edge, rising edge, high or low level.
// - Gate output is low during readout so the pulser is inhibited.
// - Gate output is high only during the exposure interval.
// - Programmed exposure spans fifty microseconds to twenty-three hours.
// - Gate appears on the auxiliary output only when software selects it.
// - Sync during a row shift is held until the shift completes.
module ftes_core #(
  parameter int unsigned ROW_CYC = 20,
  parameter int unsigned XFER_CYC = 4000,
  parameter int unsigned READ_W = 24,
  parameter logic [READ_W-1:0] READ_CYC = READ_W'(14000000)
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic i_sync,
  output logic o_gate,
  output logic o_aux_out,
  output logic o_xfer,
  output logic o_row_shift,
  output logic o_frame_valid,
  output logic o_frame_keep
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0] mode;
  logic [1:0] sync_sel;
  logic aux_sel;
  logic [ftes_pkg::EXP_W-1:0] expo;
  logic [15:0] frames;
  logic [15:0] stored;
  logic start_p;
  logic stop_p;
  logic [1:0] next_mode;
  logic [1:0] next_sync_sel;
  logic next_aux_sel;
  logic [ftes_pkg::EXP_W-1:0] next_expo;
  logic [15:0] next_frames;
  logic next_start_p;
  logic next_stop_p;
  logic [31:0] next_prdata;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  ftes_pkg::ftes_state_t state;
  ftes_pkg::ftes_state_t next_state;
  logic [ftes_pkg::EXP_W-1:0] timer;
  logic [ftes_pkg::EXP_W-1:0] next_timer;
  logic [15:0] left;
  logic [15:0] next_left;
  logic [15:0] next_stored;
  logic first;
  logic next_first;
  logic pend;
  logic next_pend;
  logic [7:0] row_cnt;
  logic [7:0] next_row_cnt;
  logic rd_start;
  logic rd_busy;
  logic sync_hit;
  logic next_gate;
  logic next_xfer;
  logic next_row_shift;
  logic next_fv;
  logic next_fk;
  logic next_aux;

  logic wr;
  logic rd;
  logic [ftes_pkg::EXP_W-1:0] expo_clip;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign pready = 1'b1;

  // Clamp so software cannot program below the minimum or above the maximum.
  always_comb begin
    if (expo < ftes_pkg::EXP_W'(ftes_pkg::EXP_MIN_CYC)) begin
      expo_clip = ftes_pkg::EXP_W'(ftes_pkg::EXP_MIN_CYC);
    end else if (expo > ftes_pkg::EXP_W'(ftes_pkg::EXP_MAX_CYC)) begin
      expo_clip = ftes_pkg::EXP_W'(ftes_pkg::EXP_MAX_CYC);
    end else begin
      expo_clip = expo;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == ftes_pkg::OFS_CTRL) || (a == ftes_pkg::OFS_EXPO_LO) || (a == ftes_pkg::OFS_EXPO_HI) ||
             (a == ftes_pkg::OFS_FRAMES) || (a == ftes_pkg::OFS_STATUS) || (a == ftes_pkg::OFS_STORED);
  endfunction

  assign pslverr = psel & penable & ~mapped(paddr);

  always_comb begin
    next_mode = mode;
    next_sync_sel = sync_sel;
    next_aux_sel = aux_sel;
    next_expo = expo;
    next_frames = frames;
    next_start_p = 1'b0;
    // Held through a transfer, which only looks at stop on its last cycle
    next_stop_p = stop_p & (state == ftes_pkg::FTES_ST_XFER);
    next_prdata = prdata;
    if (wr && paddr == ftes_pkg::OFS_CTRL) begin
      next_start_p = pwdata[ftes_pkg::CTRL_START];
      next_stop_p = next_stop_p | pwdata[ftes_pkg::CTRL_STOP];
      next_mode = pwdata[ftes_pkg::CTRL_MODE_LSB +: 2];
      next_sync_sel = pwdata[ftes_pkg::CTRL_SYNC_LSB +: 2];
      next_aux_sel = pwdata[ftes_pkg::CTRL_AUX_SEL];
    end else if (wr && paddr == ftes_pkg::OFS_EXPO_LO) begin
      next_expo = {expo[ftes_pkg::EXP_W-1:32], pwdata};
    end else if (wr && paddr == ftes_pkg::OFS_EXPO_HI) begin
      next_expo = {pwdata[ftes_pkg::EXP_W-33:0], expo[31:0]};
    end else if (wr && paddr == ftes_pkg::OFS_FRAMES) begin
      next_frames = pwdata[15:0];
    end
    if (rd) begin
      if (paddr == ftes_pkg::OFS_CTRL) begin
        next_prdata = {25'h0, aux_sel, sync_sel, mode, 2'h0};
      end else if (paddr == ftes_pkg::OFS_EXPO_LO) begin
        next_prdata = expo[31:0];
      end else if (paddr == ftes_pkg::OFS_EXPO_HI) begin
        next_prdata = {{(64 - ftes_pkg::EXP_W){1'b0}}, expo[ftes_pkg::EXP_W-1:32]};
      end else if (paddr == ftes_pkg::OFS_FRAMES) begin
        next_prdata = {16'h0, frames};
      end else if (paddr == ftes_pkg::OFS_STATUS) begin
        next_prdata = {8'h00, left, rd_busy, pend, first, state};
      end else if (paddr == ftes_pkg::OFS_STORED) begin
        next_prdata = {16'h0, stored};
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= 2'h0;
      sync_sel <= 2'h0;
      aux_sel <= 1'b0;
      expo <= ftes_pkg::EXPO_RESET;
      frames <= ftes_pkg::FRAMES_RESET;
      start_p <= 1'b0;
      stop_p <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      mode <= next_mode;
      sync_sel <= next_sync_sel;
      aux_sel <= next_aux_sel;
      expo <= next_expo;
      frames <= next_frames;
      start_p <= next_start_p;
      stop_p <= next_stop_p;
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Sync conditioning and readout engine
  // ----------------------------------------------------------------
  ftes_sync_detect u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_sync(i_sync),
    .i_sel(sync_sel),
    .o_hit(sync_hit)
  );

  ftes_readout #(.CYC_W(READ_W)) u_read (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_start(rd_start),
    .i_cycles(READ_CYC),
    .o_busy(rd_busy)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic row_end;
  logic ext;
  assign ext = (mode == ftes_pkg::FTES_MODE_EXT);
  assign row_end = (row_cnt == 8'(ROW_CYC - 1));

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_left = left;
    next_stored = stored;
    next_first = first;
    next_pend = pend;
    next_row_cnt = row_end ? 8'h00 : row_cnt + 8'h01;
    next_row_shift = row_end & rd_busy;
    next_fv = 1'b0;
    next_fk = 1'b0;
    rd_start = 1'b0;
    // Level-accepted sync is only taken in the wait or expose state, else it would retrigger.
    if (ext && sync_hit && (state == ftes_pkg::FTES_ST_WAIT || state == ftes_pkg::FTES_ST_EXPOSE)) begin
      next_pend = 1'b1;
    end
    case (state)
      ftes_pkg::FTES_ST_IDLE: begin
        next_pend = 1'b0;
        if (start_p) begin
          next_left = frames;
          next_stored = 16'h0000;
          next_first = 1'b1;
          next_timer = '0;
          next_state = ext ? ftes_pkg::FTES_ST_WAIT : ftes_pkg::FTES_ST_EXPOSE;
        end
      end
      ftes_pkg::FTES_ST_WAIT: begin
        // Sync is held until the storage readout and current row shift end.
        if (pend && !rd_busy && (row_end || !o_row_shift)) begin
          next_pend = 1'b0;
          next_timer = '0;
          next_state = ftes_pkg::FTES_ST_XFER;
        end
      end
      ftes_pkg::FTES_ST_EXPOSE: begin
        next_timer = timer + ftes_pkg::EXP_W'(1);
        if (timer + ftes_pkg::EXP_W'(1) >= expo_clip && !rd_busy) begin
          next_timer = '0;
          next_state = ext ? ftes_pkg::FTES_ST_WAIT : ftes_pkg::FTES_ST_XFER;
        end
      end
      ftes_pkg::FTES_ST_XFER: begin
        next_timer = timer + ftes_pkg::EXP_W'(1);
        if (timer == ftes_pkg::EXP_W'(XFER_CYC - 1)) begin
          next_timer = '0;
          rd_start = 1'b1;
          next_fv = 1'b1;
          next_fk = ~(ext & first);
          next_first = 1'b0;
          if (!(ext && first)) begin
            next_stored = stored + 16'h0001;
            next_left = left - 16'h0001;
          end
          if (stop_p || (left == 16'h0001 && !(ext && first))) begin
            next_state = ftes_pkg::FTES_ST_DRAIN;
          end else begin
            // Sync mode: exposure runs from sync to sync, not the programmed time
            next_state = ext ? ftes_pkg::FTES_ST_WAIT : ftes_pkg::FTES_ST_EXPOSE;
          end
        end
      end
      default: begin
        if (!rd_busy) begin
          next_state = ftes_pkg::FTES_ST_IDLE;
        end
      end
    endcase
    if (stop_p && state != ftes_pkg::FTES_ST_XFER) begin
      next_state = ftes_pkg::FTES_ST_DRAIN;
    end
    // Gate only while exposing with storage readout finished.
    next_gate = (next_state == ftes_pkg::FTES_ST_EXPOSE || next_state == ftes_pkg::FTES_ST_WAIT) &&
                !(rd_busy || rd_start) && !(ext && next_first);
    next_xfer = (next_state == ftes_pkg::FTES_ST_XFER);
    next_aux = aux_sel & next_gate;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ftes_pkg::FTES_ST_IDLE;
      timer <= '0;
      left <= 16'h0000;
      stored <= 16'h0000;
      first <= 1'b0;
      pend <= 1'b0;
      row_cnt <= 8'h00;
      o_gate <= 1'b0;
      o_aux_out <= 1'b0;
      o_xfer <= 1'b0;
      o_row_shift <= 1'b0;
      o_frame_valid <= 1'b0;
      o_frame_keep <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      left <= next_left;
      stored <= next_stored;
      first <= next_first;
      pend <= next_pend;
      row_cnt <= next_row_cnt;
      o_gate <= next_gate;
      o_aux_out <= next_aux;
      o_xfer <= next_xfer;
      o_row_shift <= next_row_shift;
      o_frame_valid <= next_fv;
      o_frame_keep <= next_fk;
    end
  end
endmodule
`default_nettype wire

//--- include/ftes_pkg.sv
// Package for the frame-transfer exposure sequencer: register map, field
// positions, reset values, modes and timing counts.
// Assumes a 200 MHz controller clock and a 32-bit APB register bus.
`default_nettype none
package ftes_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned EXP_MIN_US = 50;
  localparam int unsigned EXP_MIN_CYC = (EXP_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned EXP_MAX_HOURS = 23;
  localparam longint unsigned EXP_MAX_CYC = 64'(EXP_MAX_HOURS) * 64'd3600 * 64'd1000000000000 / 64'(CLK_PERIOD_PS);
  localparam int unsigned EXP_W = 44;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_EXPO_LO = 12'h004;
  localparam logic [11:0] OFS_EXPO_HI = 12'h008;
  localparam logic [11:0] OFS_FRAMES = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_STORED = 12'h014;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_STOP = 1;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CTRL_SYNC_LSB = 4;
  localparam int unsigned CTRL_AUX_SEL = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [EXP_W-1:0] EXPO_RESET = EXP_W'(EXP_MIN_CYC);
  localparam logic [15:0] FRAMES_RESET = 16'h0001;

  // ----------------------------------------------------------------
  // Modes, sync selections and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FTES_MODE_SOFT = 2'h0,
    FTES_MODE_FREE = 2'h1,
    FTES_MODE_EXT = 2'h2
  } ftes_mode_t;

  typedef enum logic [1:0] {
    FTES_SYNC_FALL = 2'h0,
    FTES_SYNC_RISE = 2'h1,
    FTES_SYNC_HIGH = 2'h2,
    FTES_SYNC_LOW = 2'h3
  } ftes_sync_t;

  typedef enum logic [4:0] {
    FTES_ST_IDLE = 5'h01,
    FTES_ST_EXPOSE = 5'h02,
    FTES_ST_XFER = 5'h04,
    FTES_ST_WAIT = 5'h08,
    FTES_ST_DRAIN = 5'h10
  } ftes_state_t;
endpackage
`default_nettype wire

//--- logic/ftes_sync_detect.sv
// Sync input conditioner: two-stage synchroniser then edge or level detect.
// Assumes the external sync pin is asynchronous to i_clock.
`default_nettype none
module ftes_sync_detect (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_sync,
  input wire logic [1:0] i_sel,
  output logic o_hit
);
  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  logic meta;
  logic sync_q;
  logic prev_q;
  logic next_meta;
  logic next_sync_q;
  logic next_prev_q;

  always_comb begin
    next_meta = i_sync;
    next_sync_q = meta;
    next_prev_q = sync_q;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta <= next_meta;
      sync_q <= next_sync_q;
      prev_q <= next_prev_q;
    end
  end

  // ----------------------------------------------------------------
  // Detection, only after the second stage
  // ----------------------------------------------------------------
  always_comb begin
    case (ftes_pkg::ftes_sync_t'(i_sel))
      ftes_pkg::FTES_SYNC_FALL: o_hit = prev_q & ~sync_q;
      ftes_pkg::FTES_SYNC_RISE: o_hit = ~prev_q & sync_q;
      ftes_pkg::FTES_SYNC_HIGH: o_hit = sync_q;
      default: o_hit = ~sync_q;
    endcase
  end
endmodule
`default_nettype wire

//--- logic/ftes_readout.sv
// Storage-half readout engine: reads rows out of the storage half while
// the sensing half keeps exposing. Assumes a start pulse only when idle.
`default_nettype none
module ftes_readout #(
  parameter int unsigned CYC_W = 24
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [CYC_W-1:0] i_cycles,
  output logic o_busy
);
  // ----------------------------------------------------------------
  // Readout counter
  // ----------------------------------------------------------------
  logic [CYC_W-1:0] left;
  logic [CYC_W-1:0] next_left;

  always_comb begin
    next_left = left;
    if (i_start) begin
      next_left = i_cycles;
    end else if (left != '0) begin
      next_left = left - CYC_W'(1);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left <= '0;
    end else begin
      left <= next_left;
    end
  end

  assign o_busy = (left != '0);
endmodule
`default_nettype wire

//--- testbench/ftes_core_props.sv
// Port checker for the exposure sequencer core, bound to every instance.
// Assumes the control word changes only through APB writes.
`default_nettype none
module ftes_core_props #(
  parameter int unsigned ROW_CYC = 20,
  parameter int unsigned XFER_CYC = 4000,
  parameter int unsigned READ_W = 24,
  parameter logic [READ_W-1:0] READ_CYC = READ_W'(14000000)
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic o_gate,
  input wire logic o_aux_out,
  input wire logic o_xfer,
  input wire logic o_row_shift,
  input wire logic o_frame_valid,
  input wire logic o_frame_keep
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  logic ctrl_wr;
  logic [1:0] mode_q, next_mode;
  logic aux_q, next_aux, run_q, next_run;
  logic [31:0] xlen, next_xlen, rgap, next_rgap;
  logic [READ_W-1:0] since, next_since;
  assign ctrl_wr = psel && penable && pwrite && paddr == ftes_pkg::OFS_CTRL;
  always_comb begin
    next_mode = ctrl_wr ? pwdata[3:2] : mode_q;
    next_aux = ctrl_wr ? pwdata[6] : aux_q;
    next_run = ctrl_wr ? pwdata[0] || (run_q && !pwdata[1]) : run_q;
    next_xlen = o_xfer ? xlen + 32'h1 : 32'h0;
    next_rgap = o_row_shift ? 32'h1 : rgap + 32'(rgap < 32'hFFFF);
    // Saturates so an idle gap never wraps
    next_since = o_xfer ? '0 : since + READ_W'(since < READ_CYC);
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= 2'h0;
      aux_q <= 1'h0;
      run_q <= 1'h0;
      xlen <= 32'h0;
      rgap <= 32'hFFFF;
      since <= READ_CYC;
    end else begin
      mode_q <= next_mode;
      aux_q <= next_aux;
      run_q <= next_run;
      xlen <= next_xlen;
      rgap <= next_rgap;
      since <= next_since;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  sequence xfer_end_s;
    $fell(o_xfer);
  endsequence
  sequence xfer_start_s;
    $rose(o_xfer);
  endsequence
  gate_xfer_a: assert property (o_xfer |-> !o_gate)
    else $error("gate high in transfer");
  xfer_len_a: assert property (xfer_end_s |-> xlen == XFER_CYC)
    else $error("transfer length wrong");
  frame_end_a: assert property (xfer_end_s |-> o_frame_valid || $past(o_frame_valid))
    else $error("no frame at transfer end");
  valid_cause_a: assert property (o_frame_valid |-> $past(o_xfer) || $past(o_xfer, 2))
    else $error("frame without transfer");
  keep_valid_a: assert property (o_frame_keep |-> o_frame_valid)
    else $error("keep without frame");
  free_next_a: assert property ((mode_q == ftes_pkg::FTES_MODE_FREE && run_q && $rose(since == READ_CYC))
    |=> ##[0:2] o_gate) else $error("free run did not re-expose");
  read_gap_a: assert property (xfer_start_s |-> since >= READ_CYC)
    else $error("transfer during readout");
  row_gap_a: assert property (o_row_shift |-> rgap >= ROW_CYC)
    else $error("row shifts too close");
  aux_off_a: assert property (!aux_q && !$past(aux_q) |-> !o_aux_out)
    else $error("aux out while unselected");
  apb_resp_a: assert property (psel && penable |-> pready && pslverr == (paddr > ftes_pkg::OFS_STORED))
    else $error("bad bus response");
endmodule
bind ftes_core ftes_core_props #(
  .ROW_CYC(ROW_CYC), .XFER_CYC(XFER_CYC), .READ_W(READ_W), .READ_CYC(READ_CYC)
) u_props (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .o_gate(o_gate),
  .o_aux_out(o_aux_out), .o_xfer(o_xfer), .o_row_shift(o_row_shift),
  .o_frame_valid(o_frame_valid), .o_frame_keep(o_frame_keep)
);
`default_nettype wire

//--- testbench/ftes_partner.sv
// Far side model: experiment sync source and intensifier gate pulser.
// Assumes the bench calls its tasks from the sequencer clock domain.
`default_nettype none
module ftes_partner (
  input wire logic i_clock,
  input wire logic i_gate,
  output logic o_sync,
  output logic o_shot
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] tick = 3'h0;
  initial o_sync = 1'h1;
  always @(posedge i_clock) tick <= tick + 3'h1;
  // Pulser fires only while the gate enables it
  assign o_shot = i_gate && tick == 3'h0;
  task automatic level(input logic v);
    @(posedge i_clock);
    o_sync <= v;
  endtask
  // Four clocks wide so the synchroniser always sees it
  task automatic pulse(input logic act, input int gap);
    @(posedge i_clock);
    o_sync <= act;
    repeat (4) @(posedge i_clock);
    o_sync <= ~act;
    repeat (gap) @(posedge i_clock);
  endtask
endmodule
`default_nettype wire

//--- testbench/ftes_core_tb_top.sv
// Testbench top: APB master, sync source and frame counters for the core.
// Assumes short readout and transfer counts set at the instance.
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module ftes_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_rst_n, psel, penable, pwrite, pready, pslverr, err, act;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic o_gate, o_aux_out, o_xfer, o_row_shift, o_frame_valid, o_frame_keep, sync_line, shot;
  int num_errors, check_count, nv, nk, glen, glast, rsg, bad, b, k, fcnt, fper;
  ftes_core #(.ROW_CYC(20), .XFER_CYC(8), .READ_W(24), .READ_CYC(24'h0000C8)) uut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_sync(sync_line), .o_gate(o_gate), .o_aux_out(o_aux_out), .o_xfer(o_xfer),
    .o_row_shift(o_row_shift), .o_frame_valid(o_frame_valid), .o_frame_keep(o_frame_keep));
  ftes_partner ptn (.i_clock(i_clock), .i_gate(o_gate), .o_sync(sync_line), .o_shot(shot));
  initial begin
    i_clock = 1'h0;
    forever #2.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    nv <= nv + int'(o_frame_valid === 1'h1);
    nk <= nk + int'(o_frame_valid === 1'h1 && o_frame_keep === 1'h1);
    rsg <= rsg + int'(o_row_shift === 1'h1 && o_gate === 1'h1);
    bad <= bad + int'(shot === 1'h1 && o_xfer === 1'h1);
    glen <= (o_gate === 1'h1) ? glen + 1 : 0;
    if (o_gate !== 1'h1 && glen != 0) glast <= glen;
    fcnt <= (o_frame_valid === 1'h1) ? 0 : fcnt + 1;
    if (o_frame_valid === 1'h1) fper <= fcnt + 1;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic fail_wait;
    num_errors++;
    $display("[ERR] wait limit exp 1 got 0");
    complete_run;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) fail_wait;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge i_clock);
  endtask
  task automatic wait_nv(input int t);
    int n;
    n = 0;
    while (nv < t && n < 30000) begin
      @(posedge i_clock);
      n++;
    end
    if (n >= 30000) fail_wait;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'h0, ftes_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rd[4:0] !== 5'h01 && n < 5000);
    if (n >= 5000) fail_wait;
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] s, input logic a);
    return {25'h0, a, s, m, 2'h1};
  endfunction
  initial begin
    i_rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'h1;
    @(posedge i_clock);
    apb(1'h0, ftes_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl", ftes_pkg::CTRL_RESET, rd)
    apb(1'h0, ftes_pkg::OFS_EXPO_LO, 32'h0);
    `CHK("expo", ftes_pkg::EXPO_RESET[31:0], rd)
    apb(1'h0, ftes_pkg::OFS_FRAMES, 32'h0);
    `CHK("frames", 32'(ftes_pkg::FRAMES_RESET), rd)
    apb(1'h0, 12'h018, 32'h0);
    `CHK("slverr", 1'h1, err)
    `CHK("unmapped", 32'h0, rd)
    $display("register test done");
    apb(1'h1, ftes_pkg::OFS_FRAMES, 32'h2);
    apb(1'h1, ftes_pkg::OFS_EXPO_LO, 32'h5);
    apb(1'h1, ftes_pkg::OFS_EXPO_HI, 32'h0);
    b = nv;
    k = nk;
    apb(1'h1, ftes_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 1'h1));
    ptn.pulse(1'h0, 100);
    `CHK("aux", 1'h1, o_aux_out)
    `CHK("gate", 1'h1, o_gate)
    // First exposure only: later ones keep the gate shut during readout
    wait_nv(b + 1);
    `CHK("min expo", 1'h1, glast >= ftes_pkg::EXP_MIN_CYC && glast <= ftes_pkg::EXP_MIN_CYC + 2)
    wait_nv(b + 2);
    wait_idle;
    `CHK("soft frames", 2, nv - b)
    `CHK("soft kept", 2, nk - k)
    apb(1'h0, ftes_pkg::OFS_STORED, 32'h0);
    `CHK("soft stored", 2, rd)
    $display("soft test done");
    apb(1'h1, ftes_pkg::OFS_FRAMES, 32'hFF);
    b = nv;
    k = nk;
    apb(1'h1, ftes_pkg::OFS_CTRL, ctl(2'h1, 2'h0, 1'h0));
    ptn.pulse(1'h0, 100);
    `CHK("aux off", 1'h0, o_aux_out)
    wait_nv(b + 2);
    apb(1'h1, ftes_pkg::OFS_CTRL, 32'h2);
    wait_idle;
    `CHK("free frames", 1'h1, nv - b >= 2)
    `CHK("free kept", nv - b, nk - k)
    `CHK("read in expo", ftes_pkg::EXP_MIN_CYC + 8, fper)
    `CHK("gate in read", 0, rsg)
    $display("free test done");
    for (int s = 0; s < 4; s++) begin
      act = (s == 1 || s == 2);
      ptn.level(~act);
      apb(1'h1, ftes_pkg::OFS_CTRL, ctl(2'h2, s[1:0], 1'h0));
      b = nv;
      k = nk;
      ptn.pulse(act, 600);
      ptn.pulse(act, 100);
      ptn.pulse(act, 600);
      ptn.pulse(act, 600);
      wait_nv(b + 4);
      apb(1'h1, ftes_pkg::OFS_CTRL, 32'h2);
      wait_idle;
      `CHK("sync frames", 4, nv - b)
      `CHK("sync kept", 3, nk - k)
      apb(1'h0, ftes_pkg::OFS_STORED, 32'h0);
      `CHK("sync stored", 3, rd)
      $display("sync mode %0d done", s);
    end
    `CHK("pulser in xfer", 0, bad)
    complete_run;
  end
endmodule
`default_nettype wire
